/* File: verilog/dpll_ctrl_pins.sv */
// control and status pin logic of the main loop with its shared serial host port
//
// Behaviour
// - hitless enable high gives hitless reference switching
// - hitless low disables it and realigns phase
// - software register can also control hitless
// - mode pins sampled at reset give default
// - after reset mode from pins or register
// - slave select high slave, low master, software too
// - each differential output enabled high, tristated low
// - locked flag high when frequency and phase locked
// - holdover flag high while in holdover
// - strap 0 sck input, 1 scl input, never driven
// - strap 0 si input, 1 bidirectional sda
// - strap 0 so output, 1 unused
// - select pin is chip select or address bit
// - strap high enables i2c, low spi
// - device held in reset while reset low
`timescale 1ns/100ps
module dpll_ctrl_pins #(
  parameter logic [5:0] I2C_DEV_BASE = 6'h34 // upper six bits of the device address, arbitrary
) (
  input wire logic I_CLOCK, // 40 MHz system clock
  input wire logic I_ARST_N, // async reset, active low
  input wire logic I_HITLESS_PIN, // main_loop_hitless_enable pin
  input wire logic I_MODE_PIN_LOW, // main_loop_mode_pin_low
  input wire logic I_MODE_PIN_HIGH, // main_loop_mode_pin_high
  input wire logic I_SLAVE_PIN, // master/slave select pin
  input wire logic I_DIFF_A_PIN, // differential_output_a_enable
  input wire logic I_DIFF_B_PIN, // differential_output_b_enable
  input wire logic I_I2C_STRAP, // interface-select strap
  input wire logic I_SCK_SCL, // shared serial clock pin level
  input wire logic I_SI_SDA, // shared serial data pin level
  input wire logic I_SEL_ADDR, // host_select_or_addr_bit pin
  input wire logic I_FREQ_LOCKED, // loop core: frequency locked
  input wire logic I_PHASE_LOCKED, // loop core: phase locked
  input wire logic I_IN_HOLDOVER, // loop core: holdover state
  output logic O_HITLESS_EN, // to loop core: hitless switching on
  output logic O_PHASE_REALIGN, // to loop core: realign to selected reference
  output logic [1:0] O_LOOP_MODE, // to loop core: operating mode
  output logic O_SLAVE_MODE, // to core: 1 slave, 0 master
  output logic O_DIFF_A_OE, // differential output a driver enable
  output logic O_DIFF_B_OE, // differential output b driver enable
  output logic O_LOCKED, // main_loop_locked_flag pin
  output logic O_HOLDOVER, // main_loop_holdover_flag pin
  output logic O_I2C_EN, // i2c host interface active
  output logic O_SPI_EN, // spi host interface active
  output logic O_SCL_O, // scl output level
  output logic O_SCL_OE, // scl output enable
  output logic O_SDA_O, // sda output level
  output logic O_SDA_OE, // sda output enable
  output logic O_SO, // spi serial data out
  output logic O_SO_OE // spi serial data out enable
);
  dpll_ctrl_pkg::ctrl_pins_t ctl_raw, ctl; // control pins raw and synchronised
  dpll_ctrl_pkg::host_pins_t host_raw, host; // serial pins raw and synchronised
  dpll_ctrl_pkg::ser_state_t st_ff; // serial engine state
  logic [1:0] cap_cnt_ff; // edges since reset release
  logic cap_done_ff; // straps captured
  logic cap_pulse; // capture cycle
  logic i2c_ff; // captured interface strap
  logic [7:0] mode_reg_ff; // main_loop_mode_register
  logic [7:0] ctrl_reg_ff; // override register
  logic [7:0] rdata; // read mux
  logic sck_d_ff, sd_d_ff; // previous synchronised levels
  logic sck_rise, sck_fall, i2c_start, i2c_stop; // line events
  logic [7:0] sh_ff; // receive shifter
  logic [7:0] out_ff; // transmit shifter
  logic [3:0] bcnt_ff; // bit count in current byte
  logic [6:0] addr_ff; // register address
  logic wr_stb_ff; // one-cycle register write
  logic [7:0] wr_data_ff; // data for that write
  logic so_ff, sda_oe_ff; // serial output flops
  logic [7:0] byte_in; // byte including current bit
  logic [6:0] dev_addr; // i2c device address
  logic [1:0] eff_mode; // mode chosen by pins or register
  logic [6:0] rd_addr; // address the read mux looks at

  assign ctl_raw = '{hitless: I_HITLESS_PIN, mode: {I_MODE_PIN_HIGH, I_MODE_PIN_LOW}, slave: I_SLAVE_PIN,
                     diff_a: I_DIFF_A_PIN, diff_b: I_DIFF_B_PIN, i2c_strap: I_I2C_STRAP};
  assign host_raw = '{sck: I_SCK_SCL, sd: I_SI_SDA, sel: I_SEL_ADDR};

  // every pin is asynchronous, so all pass two flops
  pin_sync2 #(.WIDTH($bits(dpll_ctrl_pkg::ctrl_pins_t))) u_sync_ctl (
    .i_clk(I_CLOCK),
    .i_arst_n(I_ARST_N),
    .i_async(ctl_raw),
    .o_sync(ctl)
  );
  pin_sync2 #(.WIDTH($bits(dpll_ctrl_pkg::host_pins_t))) u_sync_host (
    .i_clk(I_CLOCK),
    .i_arst_n(I_ARST_N),
    .i_async(host_raw),
    .o_sync(host)
  );

  // straps are caught once the synchronisers hold post-reset levels
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cap_cnt_ff <= '0;
      cap_done_ff <= 1'b0;
    end else if (!cap_done_ff) begin
      cap_cnt_ff <= cap_cnt_ff + 2'h1;
      cap_done_ff <= (cap_cnt_ff == dpll_ctrl_pkg::CAPTURE_AT);
    end
  end
  assign cap_pulse = !cap_done_ff && (cap_cnt_ff == dpll_ctrl_pkg::CAPTURE_AT);

  // interface strap is latched; changing it later would corrupt a transfer
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      i2c_ff <= 1'b0;
    end else if (cap_pulse) begin
      i2c_ff <= ctl.i2c_strap;
    end
  end

  // register file: mode default from pins, software writes afterwards
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      mode_reg_ff <= '0;
      ctrl_reg_ff <= dpll_ctrl_pkg::CTRL_RESET;
    end else if (cap_pulse) begin
      mode_reg_ff <= {6'h00, ctl.mode}; // pin code used as register code
    end else if (wr_stb_ff) begin
      if (addr_ff == dpll_ctrl_pkg::ADDR_MODE) begin
        mode_reg_ff <= wr_data_ff;
      end
      if (addr_ff == dpll_ctrl_pkg::ADDR_CTRL) begin
        ctrl_reg_ff <= wr_data_ff;
      end
    end
  end

  // pins rule the mode once straps are captured, unless software took it over
  assign eff_mode = (mode_reg_ff[dpll_ctrl_pkg::MODE_SW_BIT] || !cap_done_ff) ?
                    mode_reg_ff[dpll_ctrl_pkg::MODE_LSB +: 2] : ctl.mode;

  // a spi command byte is decoded in the cycle that snapshots the read data, so the mux sees the arriving address
  assign rd_addr = (!i2c_ff && st_ff == dpll_ctrl_pkg::ST_IDLE) ? byte_in[6:0] : addr_ff;

  // read mux, unmapped addresses read zero
  always_comb begin
    rdata = dpll_ctrl_pkg::READ_UNMAPPED;
    unique case (rd_addr)
      dpll_ctrl_pkg::ADDR_MODE: rdata = mode_reg_ff;
      dpll_ctrl_pkg::ADDR_CTRL: rdata = ctrl_reg_ff;
      dpll_ctrl_pkg::ADDR_STAT: begin
        rdata[dpll_ctrl_pkg::STAT_LOCK] = O_LOCKED;
        rdata[dpll_ctrl_pkg::STAT_HOLD] = O_HOLDOVER;
        rdata[dpll_ctrl_pkg::STAT_MODE_LSB +: 2] = O_LOOP_MODE;
        rdata[dpll_ctrl_pkg::STAT_I2C] = i2c_ff;
      end
      default: rdata = dpll_ctrl_pkg::READ_UNMAPPED;
    endcase
  end

  // loop-facing outputs, all registered
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_HITLESS_EN <= 1'b0;
      O_PHASE_REALIGN <= 1'b1; // hitless is off in reset, so realign stands
      O_LOOP_MODE <= dpll_ctrl_pkg::MODE_AUTO;
      O_SLAVE_MODE <= 1'b0;
      O_DIFF_A_OE <= 1'b0;
      O_DIFF_B_OE <= 1'b0;
      O_LOCKED <= 1'b0;
      O_HOLDOVER <= 1'b0;
    end else begin
      O_HITLESS_EN <= ctrl_reg_ff[dpll_ctrl_pkg::CTRL_HS_SW] ?
                      ctrl_reg_ff[dpll_ctrl_pkg::CTRL_HS_VAL] : ctl.hitless;
      O_PHASE_REALIGN <= ctrl_reg_ff[dpll_ctrl_pkg::CTRL_HS_SW] ?
                         !ctrl_reg_ff[dpll_ctrl_pkg::CTRL_HS_VAL] : !ctl.hitless;
      O_LOOP_MODE <= eff_mode;
      O_SLAVE_MODE <= ctrl_reg_ff[dpll_ctrl_pkg::CTRL_SL_SW] ?
                      ctrl_reg_ff[dpll_ctrl_pkg::CTRL_SL_VAL] : ctl.slave;
      O_DIFF_A_OE <= ctl.diff_a;
      O_DIFF_B_OE <= ctl.diff_b;
      O_LOCKED <= I_FREQ_LOCKED && I_PHASE_LOCKED;
      O_HOLDOVER <= I_IN_HOLDOVER;
    end
  end

  // line events seen on synchronised levels
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sck_d_ff <= 1'b0;
      sd_d_ff <= 1'b0;
    end else begin
      sck_d_ff <= host.sck;
      sd_d_ff <= host.sd;
    end
  end
  assign sck_rise = host.sck && !sck_d_ff;
  assign sck_fall = !host.sck && sck_d_ff;
  assign i2c_start = i2c_ff && host.sck && sck_d_ff && !host.sd && sd_d_ff;
  assign i2c_stop = i2c_ff && host.sck && sck_d_ff && host.sd && !sd_d_ff;
  assign byte_in = {sh_ff[6:0], host.sd};
  assign dev_addr = {I2C_DEV_BASE, host.sel}; // select pin is address bit 0 in i2c

  // serial engine: spi mode 0 command+data, or i2c pointer+data
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      st_ff <= dpll_ctrl_pkg::ST_IDLE;
      sh_ff <= '0;
      out_ff <= '0;
      bcnt_ff <= '0;
      addr_ff <= '0;
      wr_stb_ff <= 1'b0;
      wr_data_ff <= '0;
      so_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else begin
      wr_stb_ff <= 1'b0;
      if (!cap_done_ff) begin
        st_ff <= dpll_ctrl_pkg::ST_IDLE; // straps not yet known
      end else if (!i2c_ff) begin
        sda_oe_ff <= 1'b0; // sda never driven in spi
        if (host.sel) begin
          st_ff <= dpll_ctrl_pkg::ST_IDLE; // chip select high aborts
          bcnt_ff <= '0;
        end else if (sck_rise) begin
          sh_ff <= byte_in; // si sampled on rising sck
          bcnt_ff <= (bcnt_ff == dpll_ctrl_pkg::BIT_LAST) ? 4'h0 : bcnt_ff + 4'h1;
          if (bcnt_ff == dpll_ctrl_pkg::BIT_LAST) begin
            unique case (st_ff)
              dpll_ctrl_pkg::ST_IDLE, dpll_ctrl_pkg::ST_ADDR: begin
                addr_ff <= byte_in[6:0];
                st_ff <= byte_in[dpll_ctrl_pkg::SPI_RD_BIT] ? dpll_ctrl_pkg::ST_RD : dpll_ctrl_pkg::ST_WR;
              end
              dpll_ctrl_pkg::ST_WR: begin
                wr_stb_ff <= 1'b1;
                wr_data_ff <= byte_in;
              end
              default: st_ff <= st_ff;
            endcase
          end
          if (bcnt_ff == dpll_ctrl_pkg::BIT_LAST && st_ff != dpll_ctrl_pkg::ST_WR) begin
            out_ff <= rdata; // snapshot for a following read byte
          end
        end else if (sck_fall && st_ff == dpll_ctrl_pkg::ST_RD) begin
          so_ff <= out_ff[7]; // so changes on falling sck, msb first
          out_ff <= {out_ff[6:0], 1'b0};
        end
      end else if (i2c_start) begin
        st_ff <= dpll_ctrl_pkg::ST_ADDR;
        bcnt_ff <= '0;
        sda_oe_ff <= 1'b0;
      end else if (i2c_stop) begin
        st_ff <= dpll_ctrl_pkg::ST_IDLE;
        sda_oe_ff <= 1'b0;
      end else if (st_ff != dpll_ctrl_pkg::ST_IDLE) begin
        if (sck_rise && bcnt_ff < dpll_ctrl_pkg::BIT_ACK) begin
          sh_ff <= byte_in; // sda sampled on rising scl
          bcnt_ff <= bcnt_ff + 4'h1;
        end else if (sck_fall && bcnt_ff == dpll_ctrl_pkg::BIT_ACK) begin
          bcnt_ff <= dpll_ctrl_pkg::BIT_ACK_DONE;
          sda_oe_ff <= 1'b1; // acknowledge low, cleared below if not ours
          unique case (st_ff)
            dpll_ctrl_pkg::ST_ADDR: begin
              if (sh_ff[7:1] != dev_addr) begin
                st_ff <= dpll_ctrl_pkg::ST_IDLE;
                sda_oe_ff <= 1'b0;
              end else begin
                st_ff <= sh_ff[0] ? dpll_ctrl_pkg::ST_RD : dpll_ctrl_pkg::ST_REG;
                out_ff <= rdata;
              end
            end
            dpll_ctrl_pkg::ST_REG: begin
              addr_ff <= sh_ff[6:0];
              st_ff <= dpll_ctrl_pkg::ST_WR;
            end
            dpll_ctrl_pkg::ST_WR: begin
              wr_stb_ff <= 1'b1;
              wr_data_ff <= sh_ff;
            end
            default: sda_oe_ff <= 1'b0; // master acknowledges reads
          endcase
        end else if (sck_fall && (bcnt_ff == dpll_ctrl_pkg::BIT_ACK_DONE ||
                                  (st_ff == dpll_ctrl_pkg::ST_RD && bcnt_ff != dpll_ctrl_pkg::BIT_ACK))) begin
          if (bcnt_ff == dpll_ctrl_pkg::BIT_ACK_DONE) begin
            bcnt_ff <= '0;
          end
          sda_oe_ff <= (st_ff == dpll_ctrl_pkg::ST_RD) && !out_ff[7]; // open drain: drive only zeros
          if (st_ff == dpll_ctrl_pkg::ST_RD) begin
            out_ff <= {out_ff[6:0], 1'b0};
          end
        end
      end
    end
  end

  assign O_I2C_EN = i2c_ff;
  assign O_SPI_EN = cap_done_ff && !i2c_ff;
  assign O_SCL_O = 1'b0; // no clock stretching, scl only ever released
  assign O_SCL_OE = 1'b0;
  assign O_SDA_O = 1'b0; // open drain low level
  assign O_SDA_OE = i2c_ff && sda_oe_ff;
  assign O_SO = so_ff;
  assign O_SO_OE = O_SPI_EN && !host.sel; // so idle and undriven in i2c

  // checks beside the logic
  sequence s_capture;
    cap_pulse;
  endsequence

  a_hitless_pin: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    !ctrl_reg_ff[dpll_ctrl_pkg::CTRL_HS_SW] |=> O_HITLESS_EN == $past(ctl.hitless))
    else $error("hitless enable does not follow pin");
  a_realign_low: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    O_PHASE_REALIGN != O_HITLESS_EN)
    else $error("realign not opposite of hitless");
  a_hitless_sw: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    ctrl_reg_ff[dpll_ctrl_pkg::CTRL_HS_SW] |=> O_HITLESS_EN == $past(ctrl_reg_ff[dpll_ctrl_pkg::CTRL_HS_VAL]))
    else $error("software hitless ignored");
  a_mode_capture: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    s_capture |=> mode_reg_ff[1:0] == $past(ctl.mode) && cap_done_ff)
    else $error("mode pins not captured at reset release");
  a_mode_select: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    cap_done_ff && !mode_reg_ff[dpll_ctrl_pkg::MODE_SW_BIT] |=> O_LOOP_MODE == $past(ctl.mode))
    else $error("mode does not follow pins");
  a_slave_pin: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    !ctrl_reg_ff[dpll_ctrl_pkg::CTRL_SL_SW] |=> O_SLAVE_MODE == $past(ctl.slave))
    else $error("slave select wrong");
  a_diff_enable: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    1'b1 |=> O_DIFF_A_OE == $past(ctl.diff_a) && O_DIFF_B_OE == $past(ctl.diff_b))
    else $error("differential enable wrong");
  a_lock_flag: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    !(I_FREQ_LOCKED && I_PHASE_LOCKED) |=> !O_LOCKED)
    else $error("lock high without both locks");
  a_hold_flag: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    $rose(I_IN_HOLDOVER) |=> O_HOLDOVER)
    else $error("holdover flag late");
  a_scl_released: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    !O_SCL_OE)
    else $error("scl driven");
  a_sda_spi_quiet: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    !i2c_ff |-> !O_SDA_OE)
    else $error("sda driven in spi");
  a_so_unused: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    i2c_ff |-> !O_SO_OE)
    else $error("so driven in i2c");
  a_select_abort: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    cap_done_ff && !i2c_ff && host.sel |=> st_ff == dpll_ctrl_pkg::ST_IDLE)
    else $error("spi transfer survives chip select");
  a_host_enable: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    s_capture |=> O_I2C_EN == $past(ctl.i2c_strap) && O_SPI_EN != O_I2C_EN)
    else $error("host interface enable wrong");
  a_reset_release: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    $rose(cap_done_ff) |-> $past(cap_cnt_ff) == dpll_ctrl_pkg::CAPTURE_AT)
    else $error("straps captured at wrong edge");
endmodule

/* File: verilog/dpll_ctrl_pkg.sv */
// constants, types and register layout for the loop control pin block
package dpll_ctrl_pkg;
  // register indices on the serial port (7-bit address space)
  localparam logic [6:0] ADDR_MODE = 7'h1f; // main_loop_mode_register
  localparam logic [6:0] ADDR_CTRL = 7'h20; // software overrides for hitless and slave
  localparam logic [6:0] ADDR_STAT = 7'h21; // read-only loop status
  // mode register fields
  localparam int MODE_LSB = 0; // two-bit mode field
  localparam int MODE_SW_BIT = 2; // 1: register drives mode, 0: pins drive mode
  // control register fields
  localparam int CTRL_HS_VAL = 0; // software hitless value
  localparam int CTRL_HS_SW = 1; // software owns hitless enable
  localparam int CTRL_SL_VAL = 2; // software slave value
  localparam int CTRL_SL_SW = 3; // software owns slave select
  // status register fields
  localparam int STAT_LOCK = 0; // locked flag
  localparam int STAT_HOLD = 1; // holdover flag
  localparam int STAT_MODE_LSB = 2; // effective mode, two bits
  localparam int STAT_I2C = 4; // captured interface strap
  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00; // pins own everything after reset
  localparam logic [7:0] READ_UNMAPPED = 8'h00; // answer for unmapped reads
  // mode encoding follows the mode register field
  localparam logic [1:0] MODE_AUTO = 2'h0; // automatic state machine
  localparam logic [1:0] MODE_NORMAL = 2'h1; // forced locked
  localparam logic [1:0] MODE_HOLDOVER = 2'h2; // forced holdover
  localparam logic [1:0] MODE_FREERUN = 2'h3; // forced free-run
  // serial framing
  localparam logic [3:0] BIT_LAST = 4'h7; // index of eighth data bit
  localparam logic [3:0] BIT_ACK = 4'h8; // count after eight bits
  localparam logic [3:0] BIT_ACK_DONE = 4'h9; // count during acknowledge slot
  localparam int SPI_RD_BIT = 7; // command bit: 1 read, 0 write
  // reset timing
  localparam int RST_MIN_NS = 300; // least reset pulse width
  localparam int CLK_NS = 25; // system clock period
  localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS; // rounded up
  localparam logic [1:0] CAPTURE_AT = 2'h2; // edges after release before straps are valid

  // control pins that travel together through the synchroniser
  typedef struct packed {
    logic hitless; // main_loop_hitless_enable
    logic [1:0] mode; // {main_loop_mode_pin_high, main_loop_mode_pin_low}
    logic slave; // master/slave select
    logic diff_a; // differential_output_a_enable
    logic diff_b; // differential_output_b_enable
    logic i2c_strap; // interface-select strap
  } ctrl_pins_t;

  // serial host pins
  typedef struct packed {
    logic sck; // sck / scl level
    logic sd; // si / sda level
    logic sel; // host_select_or_addr_bit level
  } host_pins_t;

  // serial engine states
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001, // no transfer
    ST_ADDR = 5'b00010, // first byte: command or device address
    ST_REG = 5'b00100, // register pointer byte
    ST_WR = 5'b01000, // write data bytes
    ST_RD = 5'b10000 // read data bytes
  } ser_state_t;
endpackage

/* File: verilog/pin_sync2.sv */
// two-flop synchroniser for a bundle of asynchronous pin levels
`timescale 1ns/100ps
module pin_sync2 #(
  parameter int WIDTH = 1 // number of levels
) (
  input wire logic i_clk, // system clock
  input wire logic i_arst_n, // async reset, active low
  input wire logic [WIDTH-1:0] i_async, // raw pin levels
  output logic [WIDTH-1:0] o_sync // levels safe to use
);
  logic [WIDTH-1:0] meta_ff; // first stage, read only by second
  logic [WIDTH-1:0] sync_ff; // second stage

  // plain two-stage capture, constant reset
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;
endmodule

/* File: dv/host_spi_model.sv */
// host-side model: spi master, or i2c master, on the shared serial pins
`timescale 1ns/100ps
module host_spi_model (
  output logic o_sck, // serial clock, still outside frames
  output logic o_si, // serial data to the device
  output logic o_sel_n, // chip select, active low
  input wire logic i_so // serial data from the device
);
  // idle: select high as the pull-up leaves it
  initial begin
    o_sck = 1'b0;
    o_si = 1'b0;
    o_sel_n = 1'b1;
  end
  // one frame of command byte then one data byte; the 100 ns steps keep every change off the system clock's rising edge
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat, output logic [7:0] rd);
    logic [15:0] word;
    word = {cmd, dat};
    rd = 8'h00;
    o_sel_n = 1'b0; // select low opens the frame
    #400;
    for (int k = 15; k >= 0; k--) begin
      o_si = word[k];
      #100;
      if (k < 8) begin
        rd[k] = i_so; // taken just before the rise, msb first
      end
      o_sck = 1'b1;
      #100;
      o_sck = 1'b0;
    end
    #200;
    o_sel_n = 1'b1;
    o_si = ~o_si; // released line must not keep its last level
    #200; // gap well above three clocks
  endtask
  // i2c register write: start, address, pointer, data, stop; acknowledge slots float high, not sampled
  task automatic i2c_wr(input logic [7:0] dev, input logic [7:0] ptr, input logic [7:0] dat);
    logic [26:0] bits;
    bits = {dev, 1'b1, ptr, 1'b1, dat, 1'b1};
    o_sck = 1'b1; // idle bus, both lines high
    o_si = 1'b1;
    #400;
    o_si = 1'b0; // start: sda falls while scl is high
    #200;
    for (int k = 26; k >= 0; k--) begin
      o_sck = 1'b0;
      #100;
      o_si = bits[k]; // data changes only while scl is low
      #100;
      o_sck = 1'b1;
      #100;
    end
    o_sck = 1'b0;
    #100;
    o_si = 1'b0;
    #100;
    o_sck = 1'b1;
    #100;
    o_si = 1'b1; // stop: sda rises while scl is high
    #400;
  endtask
endmodule

/* File: dv/dpll_ctrl_pins_tb.sv */
// self-checking bench for the loop control pin block
`timescale 1ns/100ps
module dpll_ctrl_pins_tb;
  logic clk, arst_n, hs, ml, mh, sl, da, db, strap, fl, pl, ho; // pins and core levels
  logic sck, si, sel_n; // serial pins from the host model
  logic o_hs, o_re, o_sl, o_da, o_db, o_lk, o_ho, o_i2c, o_spi, o_so, o_so_oe; // outputs seen
  logic [1:0] o_mode; // effective loop mode
  logic o_scl_o, o_scl_oe, o_sda_o, o_sda_oe; // i2c line outputs
  int sda_low; // cycles in which the device pulls sda low
  localparam logic [5:0] DEV_BASE = 6'h15; // device address upper bits, arbitrary
  logic [7:0] rd; // byte read back
  logic [31:0] r; // random draw
  int failures, tests_run, seed;
  dpll_ctrl_pins #(.I2C_DEV_BASE(DEV_BASE)) i_dpll_ctrl_pins (.I_CLOCK(clk), .I_ARST_N(arst_n),
    .I_HITLESS_PIN(hs), .I_MODE_PIN_LOW(ml),
    .I_MODE_PIN_HIGH(mh), .I_SLAVE_PIN(sl), .I_DIFF_A_PIN(da), .I_DIFF_B_PIN(db), .I_I2C_STRAP(strap),
    .I_SCK_SCL(sck), .I_SI_SDA(si), .I_SEL_ADDR(sel_n), .I_FREQ_LOCKED(fl), .I_PHASE_LOCKED(pl),
    .I_IN_HOLDOVER(ho), .O_HITLESS_EN(o_hs), .O_PHASE_REALIGN(o_re), .O_LOOP_MODE(o_mode), .O_SLAVE_MODE(o_sl),
    .O_DIFF_A_OE(o_da), .O_DIFF_B_OE(o_db), .O_LOCKED(o_lk), .O_HOLDOVER(o_ho), .O_I2C_EN(o_i2c),
    .O_SPI_EN(o_spi), .O_SCL_O(o_scl_o), .O_SCL_OE(o_scl_oe), .O_SDA_O(o_sda_o), .O_SDA_OE(o_sda_oe),
    .O_SO(o_so), .O_SO_OE(o_so_oe));
  host_spi_model i_host_spi_model (.o_sck(sck), .o_si(si), .o_sel_n(sel_n), .i_so(o_so));
  // count sda pulls on the settled falling edge
  always @(negedge clk) begin
    if (o_sda_oe === 1'b1) begin
      sda_low++;
    end
  end
  // 40 MHz system clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // verdict and end of run
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // byte comparison, counted
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // expected pin outputs: hitless, realign, slave, drivers, lock, holdover
  function automatic logic [7:0] exp_pins(input logic h, s, a, b, f, p, q);
    return {1'b0, h, ~h, s, a, b, f & p, q};
  endfunction
  // reset with a strap level; held for the least pulse width rather than two cycles
  task automatic do_reset(input logic s);
    @(negedge clk);
    arst_n = 1'b0;
    strap = s;
    repeat (dpll_ctrl_pkg::RST_MIN_CYC) @(negedge clk);
    chk("outputs in reset", 8'h40, {o_hs, o_re, o_sl, o_da, o_db, o_lk, o_ho, o_i2c});
    arst_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask
  task automatic spi(input logic [7:0] cmd, input logic [7:0] dat);
    i_host_spi_model.xfer(cmd, dat, rd);
  endtask
  // watchdog: the whole sequence needs well under 100 us
  initial begin
    #500000;
    failures++;
    close_out;
  end
  // main sequence
  initial begin
    seed = 32'hc9de;
    {hs, ml, sl, da, db, strap, fl, pl, ho} = 9'h000;
    arst_n = 1'b0;
    mh = 1'b1; // holdover code on the mode pins at capture
    do_reset(1'b0);
    chk("spi strap", 8'h02, {5'h00, o_i2c, o_spi, o_so_oe});
    spi(8'h9f, 8'h00);
    chk("mode reg after reset", 8'h02, rd);
    // random pin levels, checked once the synchroniser has settled
    repeat (24) begin
      @(negedge clk);
      r = $random(seed);
      {hs, sl, da, db, fl, pl, ho, mh, ml} = r[8:0];
      repeat (5) @(negedge clk);
      chk("pin outputs", exp_pins(hs, sl, da, db, fl, pl, ho), {1'b0, o_hs, o_re, o_sl, o_da, o_db, o_lk, o_ho});
      chk("pin mode", {6'h00, mh, ml}, {6'h00, o_mode});
    end
    // software takes mode, hitless and slave against the pins
    {hs, sl, mh, ml, fl, pl, ho} = 7'b1001110;
    spi(8'h1f, 8'h07);
    spi(8'h20, 8'h0e);
    repeat (5) @(negedge clk);
    chk("register mode", 8'h03, {6'h00, o_mode});
    chk("register hitless slave", 8'h03, {5'h00, o_hs, o_re, o_sl});
    spi(8'h9f, 8'h00);
    chk("mode reg readback", 8'h07, rd);
    spi(8'h21, 8'hff);
    spi(8'ha1, 8'h00);
    chk("status reg", 8'h0d, rd);
    spi(8'hb0, 8'h00);
    chk("unmapped read", 8'h00, rd);
    chk("sda quiet in spi", 8'h00, sda_low[7:0]);
    // i2c strap: spi side and its data output stay off
    do_reset(1'b1);
    chk("i2c strap", 8'h04, {5'h00, o_i2c, o_spi, o_so_oe});
    // i2c write of the mode register; select pin idles high, so it is address bit 0 set
    i_host_spi_model.i2c_wr({DEV_BASE, 1'b1, 1'b0}, 8'h1f, 8'h06);
    chk("i2c mode write", 8'h02, {6'h00, o_mode});
    // three acknowledge slots of one 300 ns bit each, twelve clocks apiece
    chk("i2c acknowledge cycles", 8'h24, sda_low[7:0]);
    chk("i2c line levels", 8'h00, {5'h00, o_scl_o, o_scl_oe, o_sda_o});
    close_out;
  end
endmodule
